/* File: bench/pe_read_deskew_correct_test.sv */
`default_nettype none
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module pe_read_deskew_correct_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic block_start = 1'b0;
  logic char_ready = 1'b0;
  wire logic [8:0] trk_one, trk_zero, trk_clk, char_data;
  wire logic char_valid, char_drop, char_skew, char_multi;
  wire logic skew_err, in_data;
  int errors = 0;
  int tests_run = 0;
  logic [11:0] got_q[$];
  // ------------------------------------------------------------
  // clock, far side, design
  // ------------------------------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end
  prd_chan_model u_chan (.clk(clk), .one(trk_one), .zero(trk_zero),
    .bclk(trk_clk));
  prd_deskew_top #(.ACT_WIN(40)) DUT (.CLK(clk), .SRST(srst),
    .BLOCK_START(block_start), .TRK_ONE(trk_one), .TRK_ZERO(trk_zero),
    .TRK_CLK(trk_clk), .CHAR_VALID(char_valid), .CHAR_READY(char_ready),
    .CHAR_DATA(char_data), .CHAR_DROP(char_drop), .CHAR_SKEW(char_skew),
    .CHAR_MULTI(char_multi), .SKEW_ERR(skew_err), .IN_DATA(in_data));
  // collect every accepted character with its flags
  always @(posedge clk) begin
    if (char_valid === 1'b1 && char_ready === 1'b1) begin
      got_q.push_back({char_multi, char_skew, char_drop, char_data});
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // bounded wait, then a quiet spell so late extras are caught
  task automatic wait_q(input int n);
    int k;
    for (k = 0; k < 400 && got_q.size() < n; k++) @(posedge clk);
    if (got_q.size() < n) begin
      errors++;
      give_verdict();
    end else begin
      repeat (20) @(posedge clk);
      `CHK(got_q.size(), n)
    end
  endtask
  task automatic pop_chk(input logic [11:0] e);
    logic [11:0] g;
    g = got_q.pop_front();
    `CHK(g, e)
  endtask
  task automatic blk_start;
    @(posedge clk);
    block_start <= 1'b1;
    @(posedge clk);
    block_start <= 1'b0;
  endtask
  task automatic send_n(input logic [8:0] d, input int n);
    repeat (n) u_chan.send_bits(d, 9'h000, 9'h1ff);
  endtask
  task automatic preamble(input int nz);
    blk_start();
    send_n(9'h000, nz);
    send_n(9'h1ff, 1);
    repeat (4) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // receiver stalls: buffer fills, deskew holds the rest, then drain
  task automatic t_block;
    logic [8:0] dat [4];
    dat = '{9'h103, 9'h0e0, 9'h155, 9'h001};
    char_ready <= 1'b0;
    preamble(40);
    `CHK(in_data, 1'b1)
    foreach (dat[i]) send_n(dat[i], 1);
    repeat (4) @(posedge clk);
    `CHK(char_valid, 1'b1)
    char_ready <= 1'b1;
    send_n(9'h1ff, 1);
    send_n(9'h000, 3);
    send_n(9'h103, 2); // trailing noise
    wait_q(5);
    pop_chk(12'h1ff);
    foreach (dat[i]) pop_chk({3'b000, dat[i]});
    `CHK(char_valid, 1'b0)
    `CHK(in_data, 1'b0)
    $display("t_block done");
  endtask
  // too few zeros: no preamble, nothing delivered
  task automatic t_short;
    char_ready <= 1'b1;
    preamble(22);
    `CHK(in_data, 1'b0)
    send_n(9'h103, 2);
    repeat (20) @(posedge clk);
    `CHK(got_q.size(), 0)
    $display("t_short done");
  endtask
  // single, zero-looking single, triple and double dropouts
  task automatic t_drop;
    preamble(28);
    u_chan.send_bits(9'h103, 9'h002, 9'h1ff);
    u_chan.send_bits(9'h001, 9'h001, 9'h1ff);
    u_chan.send_bits(9'h007, 9'h007, 9'h1ff);
    u_chan.send_bits(9'h155, 9'h014, 9'h1ff);
    send_n(9'h0e0, 1);
    send_n(9'h1ff, 1);
    send_n(9'h000, 2);
    wait_q(5);
    pop_chk(12'h1ff);
    pop_chk(12'h303);
    pop_chk(12'h201);
    pop_chk(12'hb41);
    pop_chk(12'h0e0);
    $display("t_drop done");
  endtask
  // one track runs ahead: four bits fit, the fifth overflows
  task automatic t_skew;
    blk_start();
    repeat (4) u_chan.send_bits(9'h000, 9'h000, 9'h001);
    repeat (4) @(posedge clk);
    `CHK(skew_err, 1'b0)
    u_chan.send_bits(9'h000, 9'h000, 9'h001);
    repeat (4) @(posedge clk);
    `CHK(skew_err, 1'b1)
    blk_start();
    @(posedge clk);
    `CHK(skew_err, 1'b0)
    $display("t_skew done");
  endtask
  // one track silent past the window: character must not be taken
  task automatic t_idle;
    preamble(28);
    u_chan.send_bits(9'h103, 9'h000, 9'h0ff);
    repeat (60) @(posedge clk);
    u_chan.send_bits(9'h103, 9'h000, 9'h100);
    repeat (20) @(posedge clk);
    `CHK(got_q.size(), 0)
    $display("t_idle done");
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK(char_valid, 1'b0)
    `CHK(in_data, 1'b0)
    t_block();
    t_short();
    t_drop();
    t_skew();
    t_idle();
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: bench/prd_chan_model.sv */
`default_nettype none
module prd_chan_model (
  input wire logic clk, // system clock
  output logic [8:0] one, // per-track one strobe
  output logic [8:0] zero, // per-track zero strobe
  output logic [8:0] bclk // per-track recovered bit clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // read channels: idle lines, clocks stand low between bits
  // ------------------------------------------------------------
  initial begin
    one = 9'h000;
    zero = 9'h000;
    bclk = 9'h000;
  end
  // one bit on every enabled track, 8 cycles a bit (160 ns)
  // data leads the clock rise by three cycles so both sync flops agree
  task automatic send_bits(input logic [8:0] d, input logic [8:0] dr,
      input logic [8:0] en);
    @(posedge clk);
    one <= (one & ~en) | (d & ~dr & en);
    zero <= (zero & ~en) | (~d & ~dr & en);
    repeat (3) @(posedge clk);
    bclk <= en;
    repeat (3) @(posedge clk);
    bclk <= 9'h000;
    // released lines invert so nothing stale looks like a held bit
    one <= one ^ en;
    zero <= zero ^ en;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: logic/prd_buf.sv */
`default_nettype none
module prd_buf #(
  parameter int W = 12
) (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // reader takes word
  output logic [W-1:0] out_data // head word
);
  // ----------------------------------------------------------------------
  // two-entry store
  // ----------------------------------------------------------------------
  logic [W-1:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic wr;
  logic rd;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // pointers and occupancy; a full buffer refuses rather than overwrites
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (wr) wr_ptr_reg <= ~wr_ptr_reg;
      if (rd) rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, wr} - {1'b0, rd};
    end
  end

  // data storage
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* File: logic/prd_defines.svh */
`ifndef PRD_DEFINES_SVH
`define PRD_DEFINES_SVH
// ----------------------------------------------------------------------
// geometry and timing
// ----------------------------------------------------------------------
`define PRD_TRACKS 9
`define PRD_STAGES 4
`define PRD_PRE_ZEROS 25
`define PRD_CLK_NS 20
`define PRD_ACT_WIN_NS 800
`define PRD_ACT_WIN_CYC (`PRD_ACT_WIN_NS / `PRD_CLK_NS)
`define PRD_BUF_W 12
`endif

/* File: logic/prd_deskew_top.sv */
`include "prd_defines.svh"
`default_nettype none
// Summary of operation
// - characters carry odd vertical parity; no block check character exists
// - characters are taken only while all nine tracks show activity, except during postamble drain
// - preamble found after about 25 zero characters then an all-ones one
// - the all-ones character closing the preamble is delivered as data
// - all-zero character is invalid unless a single dropout is flagged
// - track clock without one or zero detector output marks a dropout
// - each track has a four-stage deskew register with fill counter
// - taking a character shifts every deskew register right one stage
// - a bit arriving at a deskew register still full after that cycle's take raises skew error
// - single known dropout bit is rebuilt to give odd parity
// - two or more dropouts flag multiple-track error, no correction
// - lost start characters and trailing noise after postamble ignored
// - block opens with forty zero characters and one all-ones character
// - block closes with all-ones then forty zeros, not delivered
module prd_deskew_top #(
  parameter int ACT_WIN = `PRD_ACT_WIN_CYC
) (
  input wire logic CLK, // 50 MHz system clock
  input wire logic SRST, // sync reset, active high
  input wire logic BLOCK_START, // one-cycle pulse, new block
  input wire logic [8:0] TRK_ONE, // per-track one strobe
  input wire logic [8:0] TRK_ZERO, // per-track zero strobe
  input wire logic [8:0] TRK_CLK, // per-track recovered clock
  output logic CHAR_VALID, // character available
  input wire logic CHAR_READY, // controller takes character
  output logic [8:0] CHAR_DATA, // corrected character
  output logic CHAR_DROP, // dropout seen in character
  output logic CHAR_SKEW, // skew error seen in block
  output logic CHAR_MULTI, // multiple-track error
  output logic SKEW_ERR, // sticky skew error level
  output logic IN_DATA // preamble found, block in data
);
  localparam int NT = `PRD_TRACKS;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] ones_count(input logic [8:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NT; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and clock edge detection
  // ----------------------------------------------------------------------
  logic [8:0] clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic [8:0] one_s1_reg, one_s2_reg;
  logic [8:0] zero_s1_reg, zero_s2_reg;
  logic [8:0] arr;
  logic [8:0] arr_bit;
  logic [8:0] arr_drop;

  // two flops per pin; the third clock flop only feeds the edge finder
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clk_s1_reg <= 9'h000;
      clk_s2_reg <= 9'h000;
      clk_s3_reg <= 9'h000;
      one_s1_reg <= 9'h000;
      one_s2_reg <= 9'h000;
      zero_s1_reg <= 9'h000;
      zero_s2_reg <= 9'h000;
    end else begin
      clk_s1_reg <= TRK_CLK;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      one_s1_reg <= TRK_ONE;
      one_s2_reg <= one_s1_reg;
      zero_s1_reg <= TRK_ZERO;
      zero_s2_reg <= zero_s1_reg;
    end
  end

  // rising track clock delivers a bit; no detector output means dropout
  assign arr = clk_s2_reg & ~clk_s3_reg;
  assign arr_bit = one_s2_reg;
  assign arr_drop = ~one_s2_reg & ~zero_s2_reg;

  // ----------------------------------------------------------------------
  // activity watch
  // ----------------------------------------------------------------------
  logic [15:0] act_reg [NT];
  logic all_active;

  // a track stays active for a window after each rising track clock edge
  always_ff @(posedge CLK) begin
    for (int t = 0; t < NT; t++) begin
      if (SRST || BLOCK_START) act_reg[t] <= 16'h0000;
      else if (arr[t]) act_reg[t] <= 16'(ACT_WIN);
      else if (act_reg[t] != 16'h0000) act_reg[t] <= act_reg[t] - 16'h0001;
    end
  end

  always_comb begin
    all_active = 1'b1;
    for (int t = 0; t < NT; t++) begin
      if (act_reg[t] == 16'h0000) all_active = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // deskew registers
  // ----------------------------------------------------------------------
  logic [3:0] bits_reg [NT]; // bit 0 is the output stage
  logic [3:0] drop_reg [NT];
  logic [2:0] fill_reg [NT];
  logic [2:0] fill_next [NT];
  logic [3:0] bits_next [NT];
  logic [3:0] drop_next [NT];
  logic [8:0] ovf;
  logic all_filled;
  logic pop;
  logic buf_in_ready;
  prd_pkg::prd_state_t st_reg;

  // a character is ready once every track holds a bit
  always_comb begin
    all_filled = 1'b1;
    for (int t = 0; t < NT; t++) begin
      if (fill_reg[t] == 3'h0) all_filled = 1'b0;
    end
  end

  // draining in data is stalled by a full buffer; preamble search and trailing noise drain freely
  assign pop = all_filled &&
    ((st_reg == prd_pkg::S_POST) ||
     (all_active && (st_reg == prd_pkg::S_SEARCH || buf_in_ready)));

  // shift on take, then put the arrival in the lowest free stage
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      fill_next[t] = pop ? fill_reg[t] - 3'h1 : fill_reg[t];
      bits_next[t] = pop ? bits_reg[t] >> 1 : bits_reg[t];
      drop_next[t] = pop ? drop_reg[t] >> 1 : drop_reg[t];
      ovf[t] = arr[t] && (fill_next[t] == 3'(`PRD_STAGES));
      if (arr[t] && !ovf[t]) begin
        bits_next[t][fill_next[t][1:0]] = arr_bit[t];
        drop_next[t][fill_next[t][1:0]] = arr_drop[t];
        fill_next[t] = fill_next[t] + 3'h1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    for (int t = 0; t < NT; t++) begin
      if (SRST || BLOCK_START) begin
        fill_reg[t] <= 3'h0;
        bits_reg[t] <= 4'h0;
        drop_reg[t] <= 4'h0;
      end else begin
        fill_reg[t] <= fill_next[t];
        bits_reg[t] <= bits_next[t];
        drop_reg[t] <= drop_next[t];
      end
    end
  end

  // sticky skew error for the block
  logic skew_reg;
  always_ff @(posedge CLK) begin
    if (SRST || BLOCK_START) skew_reg <= 1'b0;
    else if (ovf != 9'h000) skew_reg <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // character assembly and correction
  // ----------------------------------------------------------------------
  logic [8:0] raw;
  logic [8:0] drp;
  logic [3:0] ndrop;
  logic [8:0] corr;
  logic multi;
  logic raw_zero;
  logic raw_ones;

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      raw[t] = bits_reg[t][0] & ~drop_reg[t][0];
      drp[t] = drop_reg[t][0];
    end
  end

  // odd parity is the only check, so a known lost bit is recoverable
  assign ndrop = ones_count(drp);
  assign multi = (ndrop > 4'h1);
  assign corr = (ndrop == 4'h1) ? (raw | (drp & {9{~^raw}})) : raw;
  assign raw_zero = (raw == 9'h000);
  assign raw_ones = (raw == 9'h1ff) && (ndrop == 4'h0);

  // ----------------------------------------------------------------------
  // block sequencing
  // ----------------------------------------------------------------------
  logic [5:0] zcnt_reg;
  logic held_v_reg;
  logic [11:0] held_reg;
  logic push;
  logic [11:0] fresh;

  assign fresh = {multi, skew_reg, ndrop != 4'h0, corr};
  // a new valid character releases the one held back, so the closing
  // all-ones of the postamble is still held when the zeros arrive
  assign push = pop && (st_reg == prd_pkg::S_DATA) && held_v_reg &&
    !(raw_zero && ndrop != 4'h1);

  // preamble search, data and postamble drain
  always_ff @(posedge CLK) begin
    if (SRST || BLOCK_START) begin
      st_reg <= prd_pkg::S_SEARCH;
      zcnt_reg <= 6'h00;
      held_v_reg <= 1'b0;
      held_reg <= 12'h000;
    end else if (pop) begin
      unique case (st_reg)
        prd_pkg::S_SEARCH: begin
          // forty zeros are written; 25 leaves slack for lost ones
          if (raw_ones && zcnt_reg >= 6'(`PRD_PRE_ZEROS)) begin
            st_reg <= prd_pkg::S_DATA;
            held_v_reg <= 1'b1;
            held_reg <= fresh;
          end else if (raw_zero && ndrop == 4'h0) begin
            if (zcnt_reg < 6'(`PRD_PRE_ZEROS)) zcnt_reg <= zcnt_reg + 6'h01;
          end else begin
            zcnt_reg <= 6'h00;
          end
        end
        prd_pkg::S_DATA: begin
          if (raw_zero && ndrop == 4'h0) begin
            st_reg <= prd_pkg::S_POST;
            held_v_reg <= 1'b0;
          end else if (!(raw_zero && ndrop != 4'h1)) begin
            held_reg <= fresh;
          end
        end
        prd_pkg::S_POST: begin
          held_v_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------------
  logic [11:0] out_word;

  prd_buf #(.W(`PRD_BUF_W)) u_buf (
    .clk(CLK),
    .srst(SRST),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(held_reg),
    .out_valid(CHAR_VALID),
    .out_ready(CHAR_READY),
    .out_data(out_word)
  );

  assign CHAR_DATA = out_word[8:0];
  assign CHAR_DROP = out_word[9];
  assign CHAR_SKEW = out_word[10];
  assign CHAR_MULTI = out_word[11];
  assign SKEW_ERR = skew_reg;
  assign IN_DATA = (st_reg == prd_pkg::S_DATA);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST || BLOCK_START);

  skew_flag_set_a: assert property (ovf != 9'h000 |=> skew_reg)
    else $error("overflow did not raise skew error");
  fill_bound_a: assert property (
    fill_reg[0] <= 3'h4 && fill_reg[8] <= 3'h4)
    else $error("deskew fill exceeds four");
  odd_parity_a: assert property (pop && ndrop == 4'h1 |-> ^corr)
    else $error("corrected character lacks odd parity");
  multi_flag_a: assert property (
    pop && ndrop >= 4'h2 |-> multi && corr == raw)
    else $error("multiple dropout not flagged");
  preamble_entry_a: assert property (
    st_reg == prd_pkg::S_SEARCH ##1 st_reg == prd_pkg::S_DATA |->
    $past(zcnt_reg) >= 6'(`PRD_PRE_ZEROS) && held_v_reg)
    else $error("data entered without preamble");
  push_in_data_a: assert property (push |-> st_reg == prd_pkg::S_DATA)
    else $error("character pushed outside data");
  zero_reject_a: assert property (
    pop && raw_zero && ndrop != 4'h1 |-> !push)
    else $error("all-zero character accepted");
  active_take_a: assert property (
    pop && st_reg != prd_pkg::S_POST |-> all_active)
    else $error("character taken without activity");
  post_silent_a: assert property (
    st_reg == prd_pkg::S_DATA && pop && raw_zero && ndrop == 4'h0 |=>
    (st_reg == prd_pkg::S_POST && !held_v_reg && !push) [*2])
    else $error("postamble delivered as data");
  shift_take_a: assert property (
    pop && !arr[0] |=> fill_reg[0] == $past(fill_reg[0]) - 3'h1)
    else $error("take did not shift deskew register");
endmodule
`default_nettype wire

/* File: logic/prd_pkg.sv */
`default_nettype none
package prd_pkg;
  // block sequencing: preamble search, data, postamble drain
  typedef enum logic [1:0] {S_SEARCH, S_DATA, S_POST} prd_state_t;
endpackage
`default_nettype wire
